// ===== core/lcd_pkg.sv
// Operation
// - enable sends 2^23-1 (E3) or 2^15-1 sequence
// - enable also arms receive checker
// - checker in sync drives violation output low
// - out of sync: loss flag set, output high
// - insert bit adds exactly one error
// - each error detected while in sync pulses output one cycle
// - error inserted only on zero-to-one write
// - sequence test forces single-rail operation
// - three loopbacks chosen by two select bits
// - analog loop routes transmit line to receive
// - analog loop keeps driving line outputs
// - analog loop ignores external receive line
// - digital loop presents transmit inputs on receive
// - remote loop returns receive data to transmit
// - remote loop still drives receive rails
// - remote loop ignores transmit rail inputs
// - all-ones bit sends AMI all-ones pattern
// - all-ones clocked at transmit clock rate
// - all-ones void in analog or remote loop
package lcd_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] LCD_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LCD_STATUS_ADDR = 8'h04;
  localparam logic [7:0] LCD_ERRCNT_ADDR = 8'h08;
  localparam int LCD_BIT_SEQ_EN    = 0;
  localparam int LCD_BIT_ERR_INS   = 1;
  localparam int LCD_BIT_ALL_ONES  = 2;
  localparam int LCD_BIT_LOCAL     = 3;
  localparam int LCD_BIT_REMOTE    = 4;
  localparam int LCD_BIT_RATE_E3   = 5;
  localparam int LCD_BIT_DUAL_RAIL = 6;
  localparam logic [6:0] LCD_CTRL_RESET = 7'h00;
  localparam int LCD_SYNC_COUNT = 24;
  localparam logic [22:0] LCD_GEN_SEED = 23'h7FFFFF;
  localparam logic [1:0] LCD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LCD_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LCD_LOOP_NONE, LCD_LOOP_ANALOG, LCD_LOOP_DIGITAL,
                            LCD_LOOP_REMOTE} lcd_loop_t;
endpackage

// ===== core/lcd_top.sv
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcd_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_clock_in,
  input  wire logic        tx_pos_rail,
  input  wire logic        tx_neg_rail,
  output logic             tx_line_pos,
  output logic             tx_line_neg,
  input  wire logic        rx_line_pos,
  input  wire logic        rx_line_neg,
  output logic             rx_clock_out,
  output logic             rx_pos_rail,
  output logic             rx_neg_violation_out
);
  import lcd_pkg::*;

  typedef struct packed {
    logic [2:0]  s_tx_clk;
    logic [2:0]  s_tx_pos;
    logic [2:0]  s_tx_neg;
    logic [2:0]  s_rx_pos;
    logic [2:0]  s_rx_neg;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic [6:0]  ctrl;
    logic        ins_prev;
    logic        ins_pending;
    logic [22:0] gen;
    logic [22:0] chk;
    logic [5:0]  good_run;
    logic        in_sync;
    logic        err_pulse;
    logic [15:0] err_count;
    logic        ones_phase;
    logic        rx_clk;
    logic        rx_pos;
    logic        rx_neg;
    logic        line_pos;
    logic        line_neg;
  } lcd_state_t;

  lcd_state_t state;
  lcd_state_t next_state;

  lcd_loop_t loop_mode;
  logic      seq_test_enable;
  logic      seq_error_insert;
  logic      all_ones_transmit;
  logic      seq_loss_of_sync;
  logic      tx_edge;
  logic      rx_edge;
  logic      gen_fb;
  logic      gen_bit;
  logic      chk_fb;
  logic      rx_bit;
  logic      src_pos;
  logic      src_neg;
  logic      wr_fire;
  logic      rd_fire;

  assign seq_test_enable   = state.ctrl[LCD_BIT_SEQ_EN];
  assign seq_error_insert  = state.ctrl[LCD_BIT_ERR_INS];
  assign all_ones_transmit = state.ctrl[LCD_BIT_ALL_ONES];
  assign seq_loss_of_sync  = seq_test_enable & ~state.in_sync;

  // ****************************************************************
  // loop select decode
  // ****************************************************************
  always_comb
  begin
    case ({state.ctrl[LCD_BIT_REMOTE], state.ctrl[LCD_BIT_LOCAL]})
      2'b00:   loop_mode = LCD_LOOP_NONE;
      2'b01:   loop_mode = LCD_LOOP_DIGITAL;
      2'b10:   loop_mode = LCD_LOOP_REMOTE;
      2'b11:   loop_mode = LCD_LOOP_ANALOG;
      default: loop_mode = LCD_LOOP_NONE;
    endcase
  end

  // transmit timing is the receive clock during remote loop
  assign tx_edge = (loop_mode == LCD_LOOP_REMOTE) ? rx_edge
                   : (state.s_tx_clk[1] & ~state.s_tx_clk[2]);
  // receive timing follows the transmit clock: loop data recovered on transmit edge
  assign rx_edge = (loop_mode == LCD_LOOP_NONE || loop_mode == LCD_LOOP_REMOTE)
                   ? (state.s_tx_clk[1] & ~state.s_tx_clk[2]) : 1'b0;

  // ****************************************************************
  // sequence generator and checker taps
  // ****************************************************************
  always_comb
  begin
    if (state.ctrl[LCD_BIT_RATE_E3])
    begin
      gen_fb = state.gen[22] ^ state.gen[17];
      chk_fb = state.chk[22] ^ state.chk[17];
    end
    else
    begin
      gen_fb = state.gen[14] ^ state.gen[13];
      chk_fb = state.chk[14] ^ state.chk[13];
    end
  end

  assign gen_bit = gen_fb ^ state.ins_pending;
  assign rx_bit  = state.rx_pos | state.rx_neg;

  // line source selection
  always_comb
  begin
    if (loop_mode == LCD_LOOP_REMOTE)
    begin
      src_pos = state.s_rx_pos[1];
      src_neg = state.s_rx_neg[1];
    end
    else if (all_ones_transmit && loop_mode != LCD_LOOP_ANALOG)
    begin
      src_pos = ~state.ones_phase;
      src_neg = state.ones_phase;
    end
    else if (seq_test_enable)
    begin
      src_pos = gen_bit;
      src_neg = 1'b0;
    end
    else if (state.ctrl[LCD_BIT_DUAL_RAIL])
    begin
      src_pos = state.s_tx_pos[1];
      src_neg = state.s_tx_neg[1];
    end
    else
    begin
      src_pos = state.s_tx_pos[1];
      src_neg = 1'b0;
    end
  end

  assign wr_fire = state.aw_hold & state.w_hold & ~state.bvalid;
  assign rd_fire = s_axi_arvalid & ~state.rvalid;

  always_comb
  begin
    next_state = state;
    next_state.s_tx_clk = {state.s_tx_clk[1:0], tx_clock_in};
    next_state.s_tx_pos = {state.s_tx_pos[1:0], tx_pos_rail};
    next_state.s_tx_neg = {state.s_tx_neg[1:0], tx_neg_rail};
    next_state.s_rx_pos = {state.s_rx_pos[1:0], rx_line_pos};
    next_state.s_rx_neg = {state.s_rx_neg[1:0], rx_line_neg};

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    if (s_axi_awvalid && !state.aw_hold)
    begin
      next_state.aw_hold = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_hold)
    begin
      next_state.w_hold = 1'b1;
      next_state.w_data = s_axi_wdata;
      if (!s_axi_wstrb[0])
        next_state.w_data[7:0] = {1'b0, state.ctrl};
    end
    if (wr_fire)
    begin
      next_state.aw_hold = 1'b0;
      next_state.w_hold  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = LCD_RESP_SLVERR;
      if (state.aw_addr == LCD_CTRL_ADDR)
      begin
        next_state.ctrl  = next_state.w_data[6:0];
        next_state.bresp = LCD_RESP_OKAY;
      end
      else if (state.aw_addr == LCD_STATUS_ADDR || state.aw_addr == LCD_ERRCNT_ADDR)
        next_state.bresp = LCD_RESP_OKAY;
    end
    if (state.bvalid && s_axi_bready)
      next_state.bvalid = 1'b0;
    if (rd_fire)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = LCD_RESP_OKAY;
      case (s_axi_araddr)
        LCD_CTRL_ADDR:   next_state.rdata = {25'h0000000, state.ctrl};
        LCD_STATUS_ADDR: next_state.rdata = {30'h00000000, state.in_sync,
                                             seq_loss_of_sync};
        LCD_ERRCNT_ADDR: next_state.rdata = {16'h0000, state.err_count};
        default:
        begin
          next_state.rdata = 32'h00000000;
          next_state.rresp = LCD_RESP_SLVERR;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready)
      next_state.rvalid = 1'b0;

    // ****************************************************************
    // single error insertion
    // ****************************************************************
    next_state.ins_prev = seq_error_insert;
    if (seq_test_enable && seq_error_insert && !state.ins_prev)
      next_state.ins_pending = 1'b1;
    if (!seq_test_enable)
      next_state.ins_pending = 1'b0;

    // ****************************************************************
    // transmit path
    // ****************************************************************
    if (tx_edge)
    begin
      if (seq_test_enable)
      begin
        next_state.gen = {state.gen[21:0], gen_fb};
        if (state.ins_pending && !(seq_error_insert && !state.ins_prev))
          next_state.ins_pending = 1'b0;
      end
      next_state.ones_phase = ~state.ones_phase;
      next_state.line_pos = src_pos;
      next_state.line_neg = src_neg;
    end

    // ****************************************************************
    // receive path
    // ****************************************************************
    next_state.err_pulse = 1'b0;
    case (loop_mode)
      LCD_LOOP_ANALOG:
      begin
        next_state.rx_clk = state.s_tx_clk[1];
        if (tx_edge)
        begin
          next_state.rx_pos = src_pos;
          next_state.rx_neg = src_neg;
        end
      end
      LCD_LOOP_DIGITAL:
      begin
        next_state.rx_clk = state.s_tx_clk[1];
        next_state.rx_pos = state.s_tx_pos[1];
        next_state.rx_neg = state.s_tx_neg[1];
      end
      default:
      begin
        next_state.rx_clk = state.s_tx_clk[1];
        if (rx_edge)
        begin
          next_state.rx_pos = state.s_rx_pos[1];
          next_state.rx_neg = state.s_rx_neg[1];
        end
      end
    endcase

    // checker updates on each fresh receive bit
    if (seq_test_enable && (tx_edge || rx_edge))
    begin
      // free-runs once locked, so one line error gives one pulse
      next_state.chk = {state.chk[21:0], state.in_sync ? chk_fb : rx_bit};
      if (rx_bit != chk_fb)
      begin
        next_state.good_run = 6'h00;
        if (state.in_sync)
        begin
          next_state.err_pulse = 1'b1;
          next_state.err_count = state.err_count + 16'h0001;
        end
        if (state.good_run == 6'h00)
          next_state.in_sync = 1'b0;
      end
      else if (state.good_run < 6'(LCD_SYNC_COUNT))
        next_state.good_run = state.good_run + 6'h01;
      else
        next_state.in_sync = 1'b1;
    end
    if (!seq_test_enable)
    begin
      next_state.in_sync  = 1'b0;
      next_state.good_run = 6'h00;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= '0;
      state.ctrl <= LCD_CTRL_RESET;
      state.gen  <= LCD_GEN_SEED;
    end
    else
      state <= next_state;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = ~state.aw_hold;
  assign s_axi_wready  = ~state.w_hold;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = ~state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign tx_line_pos   = state.line_pos;
  assign tx_line_neg   = state.line_neg;
  assign rx_clock_out  = state.rx_clk;
  assign rx_pos_rail   = state.rx_pos;
  // violation output: sync state plus error pulses in test mode
  assign rx_neg_violation_out = seq_test_enable
                                ? (~state.in_sync | state.err_pulse)
                                : state.rx_neg;
endmodule
`default_nettype wire

// ===== testbench/lcd_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checker
// ********
module lcd_top_monitor
  import lcd_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_clock_in,
  input wire logic        tx_pos_rail,
  input wire logic        tx_line_pos,
  input wire logic        rx_line_pos,
  input wire logic        rx_clock_out,
  input wire logic        rx_pos_rail
);
  logic [6:0] ctrl;
  logic       wr_ctrl;
  logic       dig;
  logic       rem;
  logic       ana;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shadow of the control byte
  assign wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign dig = !ctrl[0] && ctrl[4:3] == 2'b01;
  assign rem = !ctrl[0] && ctrl[4:3] == 2'b10;
  assign ana = !ctrl[0] && ctrl[4:3] == 2'b11;
  always_ff @(posedge aclk)
    if (!aresetn)
      ctrl <= LCD_CTRL_RESET;
    else if (wr_ctrl && s_axi_awaddr == LCD_CTRL_ADDR)
      ctrl <= s_axi_wdata[6:0];
  sequence s_wr_taken;
    wr_ctrl;
  endsequence
  property p_bresp;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > LCD_ERRCNT_ADDR |=>
      s_axi_rvalid && s_axi_rresp == LCD_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_dig_pos;
    (dig && tx_pos_rail)[*6] |-> rx_pos_rail;
  endproperty
  a_dig_pos: assert property (p_dig_pos) else $error("digital loop data");
  property p_dig_clk;
    (dig && tx_clock_in)[*6] |-> rx_clock_out;
  endproperty
  a_dig_clk: assert property (p_dig_clk) else $error("digital loop clock");
  property p_rem_rail;
    rem && $past(rem, 3) && $changed(rx_pos_rail) |-> rx_pos_rail == $past(rx_line_pos, 3);
  endproperty
  a_rem_rail: assert property (p_rem_rail) else $error("remote loop rail");
  property p_ana;
    ana && $past(ana, 3) && $changed(tx_line_pos) |-> rx_pos_rail == tx_line_pos;
  endproperty
  a_ana: assert property (p_ana) else $error("analog loop path");
endmodule
bind lcd_top lcd_top_monitor lcd_top_monitor_inst (.*);
`default_nettype wire

// ===== testbench/lcd_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// framer model
// ********
module lcd_framer_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic send,
  output logic      tx_clock_in,
  output logic      tx_pos_rail,
  output logic      tx_neg_rail
);
  logic [3:0] phase;
  logic       mark;
  // clock stands low when idle
  always_ff @(posedge aclk)
    if (!aresetn || !run)
      {phase, tx_clock_in} <= 5'h00;
    else
      {phase, tx_clock_in} <= {phase + 4'h1, phase >= 4'h7 && phase != 4'hF};
  // marks alternate, moved on the falling clock edge
  always_ff @(posedge aclk)
    if (!aresetn)
      {tx_pos_rail, tx_neg_rail, mark} <= 3'h0;
    else if (run && phase == 4'hF)
      {tx_pos_rail, tx_neg_rail, mark} <= {send && !mark, send && mark, !mark};
endmodule
`default_nettype wire

// ===== testbench/line_channel_diagnostics_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// channel diagnostics bench
// ********
module line_channel_diagnostics_bench;
  import lcd_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        run = 1'b0;
  logic        send = 1'b0;
  logic        line_src = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  logic [31:0] s_axi_rdata, rd_data, last;
  logic        tx_clock_in, tx_pos_rail, tx_neg_rail, tx_line_pos, tx_line_neg;
  logic        rx_line_pos, rx_line_neg, rx_clock_out, rx_pos_rail, rx_neg_violation_out;
  int          fails = 0;
  int          compares = 0;
  int          pr, nr, vh, vr, n;
  logic [31:0] loops [3] = '{32'h08, 32'h10, 32'h18};
  logic [31:0] rates [2] = '{32'h00, 32'h20};
  logic [31:0] ones [4] = '{32'h04, 32'h0C, 32'h1C, 32'h14};
  logic [31:0] ones_on [4] = '{32'h1, 32'h1, 32'h0, 32'h0};
  // far line: either swapped framer rails or the own line outputs
  assign rx_line_pos = line_src ? tx_neg_rail : tx_line_pos;
  assign rx_line_neg = line_src ? tx_pos_rail : tx_line_neg;
  lcd_top lcd_top_inst (.*);
  lcd_framer_model lcd_framer_model_inst (.*);
  initial forever #2.5 aclk = ~aclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic fin, ac, wc, rc, rv;
    fin = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
    for (int k = 0; k < 60 && !fin; k++)
    begin
      @(negedge aclk);
      fin = s_axi_bready && s_axi_bvalid || s_axi_rready && s_axi_rvalid;
      {ac, wc, rc} = {s_axi_awready, s_axi_wready, s_axi_arready};
      rv = s_axi_bvalid || s_axi_rvalid;
      {rd_data, rd_resp} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ac)
        s_axi_awvalid <= 1'b0;
      if (wc)
        s_axi_wvalid <= 1'b0;
      if (rc)
        s_axi_arvalid <= 1'b0;
      s_axi_bready <= wr && rv && !fin;
      s_axi_rready <= !wr && rv && !fin;
    end
    if (!fin)
    begin
      fails++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      complete_run();
    end
  endtask
  task automatic watch(input int cycles);
    logic p, q, v;
    {pr, nr, vh, vr} = '0;
    {p, q, v} = {tx_line_pos, tx_line_neg, rx_neg_violation_out};
    repeat (cycles)
    begin
      @(negedge aclk);
      pr += int'(tx_line_pos && !p);
      nr += int'(tx_line_neg && !q);
      vr += int'(rx_neg_violation_out && !v);
      vh += int'(rx_neg_violation_out);
      {p, q, v} = {tx_line_pos, tx_line_neg, rx_neg_violation_out};
    end
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, LCD_CTRL_ADDR, 32'h0);
    check(rd_data, {25'h0, LCD_CTRL_RESET});
    bus(1'b0, 8'h0C, 32'h0);
    check({rd_data[29:0], rd_resp}, {30'h0, LCD_RESP_SLVERR});
    $display("test registers finished");
    {run, send} <= 2'b11;
    foreach (loops[i])
    begin
      bus(1'b1, LCD_CTRL_ADDR, loops[i]);
      watch(200);
      check({31'h0, pr > 2}, 32'h1);
      bus(1'b0, LCD_CTRL_ADDR, 32'h0);
      check(rd_data, loops[i]);
    end
    $display("test loopbacks finished");
    {send, line_src} <= 2'b00;
    foreach (rates[i])
    begin
      bus(1'b1, LCD_CTRL_ADDR, 32'h0);
      bus(1'b1, LCD_CTRL_ADDR, rates[i] | 32'h1);
      bus(1'b0, LCD_STATUS_ADDR, 32'h0);
      @(negedge aclk);
      check({rd_data[30:0], rx_neg_violation_out}, 32'h3);
      for (n = 0; n < 300 && rd_data !== 32'h2; n++)
        bus(1'b0, LCD_STATUS_ADDR, 32'h0);
      check(rd_data, 32'h2);
      @(negedge aclk);
      check({31'h0, rx_neg_violation_out}, 32'h0);
      bus(1'b0, LCD_ERRCNT_ADDR, 32'h0);
      last = rd_data;
      for (n = 0; n < 3; n++)
      begin
        if (n == 2)
          bus(1'b1, LCD_CTRL_ADDR, rates[i] | 32'h1);
        bus(1'b1, LCD_CTRL_ADDR, rates[i] | 32'h3);
        watch(600);
        bus(1'b0, LCD_ERRCNT_ADDR, 32'h0);
        check({31'h0, rd_data == last}, {31'h0, n == 1});
        check({31'h0, vr > 0}, {31'h0, n != 1});
        check(32'(vh), 32'(vr));
        last = rd_data;
      end
    end
    $display("test sequence finished");
    line_src <= 1'b1;
    foreach (ones[i])
    begin
      bus(1'b1, LCD_CTRL_ADDR, ones[i]);
      watch(320);
      check({31'h0, pr >= 4 && nr >= 4}, ones_on[i]);
    end
    run <= 1'b0;
    bus(1'b1, LCD_CTRL_ADDR, 32'h04);
    watch(320);
    check(32'(pr + nr), 32'h0);
    $display("test all ones finished");
    complete_run();
  end
endmodule
`default_nettype wire
